// ### core/dsl_lane_dec.sv
`timescale 1ns/100ps
module dsl_lane_dec
  import dsl_pkg::*;
(
  dsl_lane_if.dec lane
);
  // Bit n of cas_n is column strobe n; strobe 0 carries the top byte lane
  always_comb begin
    lane.cas_n = CAS_NONE_N;
    case (lane.port_size)
      PORT_8: begin
        lane.cas_n = 4'hE;
      end
      PORT_16A, PORT_16B: begin
        if (lane.op_size == SIZE_BYTE) begin
          lane.cas_n = lane.addr_lo[0] ? 4'hD : 4'hE;
        end else begin
          lane.cas_n = 4'hC;
        end
      end
      default: begin
        if (lane.op_size == SIZE_BYTE) begin
          lane.cas_n = ~(4'h1 << lane.addr_lo);
        end else if (lane.op_size == SIZE_WORD) begin
          lane.cas_n = lane.addr_lo[1] ? 4'h3 : 4'hC;
        end else begin
          lane.cas_n = CAS_ALL_ON;
        end
      end
    endcase
  end
endmodule : dsl_lane_dec

// ### core/dsl_lane_if.sv
`timescale 1ns/100ps
interface dsl_lane_if;
  logic [1:0] op_size;
  logic [1:0] port_size;
  logic [1:0] addr_lo;
  logic [3:0] cas_n;
  modport dec (input op_size, input port_size, input addr_lo, output cas_n);
  modport ctl (output op_size, output port_size, output addr_lo, input cas_n);
endinterface : dsl_lane_if

// ### core/dsl_pkg.sv
package dsl_pkg;
  // Operand size codes, as driven on the transfer_size outputs
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_LINE = 2'h3;
  // Port size codes; both 2'h2 and 2'h3 mean a 16-bit port
  localparam logic [1:0] PORT_32 = 2'h0;
  localparam logic [1:0] PORT_8 = 2'h1;
  localparam logic [1:0] PORT_16A = 2'h2;
  localparam logic [1:0] PORT_16B = 2'h3;
  // Page mode select
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_FAST_PAGE = 2'h1;
  localparam logic [1:0] MODE_BURST_PAGE = 2'h2;
  // dram_timing_register field positions, each field two bits wide
  localparam int TMR_RCD_LSB = 0;
  localparam int TMR_CASW_LSB = 2;
  localparam int TMR_RP_LSB = 4;
  localparam int TMR_RFSH_LSB = 6;
  localparam int TMR_FIELD_W = 2;
  localparam int TMR_W = 8;
  localparam logic [7:0] TMR_RESET = 8'h00;
  // Bank geometry: column bits give 128 KByte up to 256 MByte per bank
  localparam int ADDR_W = 28;
  localparam int COL_BITS_MIN = 8;
  localparam logic [3:0] COL_BITS_RESET = 4'h8;
  // Refresh timer: period is (rate + 1) * REFRESH_UNIT cycles
  localparam int RATE_W = 12;
  localparam int REFRESH_UNIT = 16;
  localparam int RTMR_W = 17;
  localparam logic [3:0] CAS_ALL_N = 4'hF;
  localparam logic [3:0] CAS_NONE_N = 4'hF;
  localparam logic [3:0] CAS_ALL_ON = 4'h0;
  localparam logic [1:0] RAS_OFF_N = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ROW = 4'h1,
    ST_COL = 4'h3,
    ST_CGAP = 4'h2,
    ST_PAGE = 4'h6,
    ST_PRE = 4'h7,
    ST_RF_CAS = 4'h5,
    ST_RF_RAS = 4'h4
  } dsl_state_t;

  typedef struct packed {
    dsl_state_t st;
    logic [2:0] cnt;
    logic [4:0] beats;
    logic [ADDR_W-1:0] addr;
    logic [1:0] size;
    logic wr;
    logic bank;
    logic ext;
    logic [ADDR_W-1:0] open_row;
    logic [RTMR_W-1:0] rtmr;
    logic rfsh_pend;
    logic [1:0] ras_n;
    logic [3:0] cas_n;
    logic we_n;
    logic [ADDR_W-1:0] addr_out;
    logic [1:0] tsize;
    logic done;
    logic data_stb;
    logic edo_stb;
    logic busy;
    logic rfsh_act;
  } dsl_regs_t;
endpackage : dsl_pkg

// ### core/dsl_top.sv
`timescale 1ns/100ps
// Overview of operation
// - Two banks, each with its own row strobe: strobe 0 bank 0, strobe 1 bank 1.
// - Each bank sized from 128 KByte to 256 MByte.
// - Each bank may be 8, 16 or 32 bits wide.
// - Row and column strobes are active low.
// - Column strobes 0..3 enable byte lanes 31:24, 23:16, 15:8, 7:0.
// - 32-bit bank uses four strobes, 16-bit two, 8-bit only strobe 0.
// - Byte: 8-bit strobe 0; 16-bit by A0; 32-bit strobe by A1:A0.
// - Word: 8-bit strobe 0; 16-bit 0 and 1; 32-bit pair chosen by A1.
// - Longword and line: strobe 0, strobes 0-1, or all four by port width.
// - Transfer size outputs equal operand size: 01 byte, 10 word, 00 long, 11 line.
// - Write strobe low through DRAM writes, high through DRAM reads.
// - Write strobe stays high during refresh whatever other bus direction.
// - Write strobe only meaningful during DRAM transfers; others ignore it otherwise.
// - Internal timer starts CAS-before-RAS refresh at a software set rate.
// - Row and column addresses are multiplexed onto the address outputs here.
// - Strobe timing follows the programmable timing register.
// - Normal, fast page and burst page modes, plus extended-data-out parts.
// - External bus masters may use the controller to reach the banks.
module dsl_top
  import dsl_pkg::*;
#(
  parameter int REFRESH_UNIT_P = REFRESH_UNIT
)(
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic REQ_VALID_IN,
  input wire logic REQ_WRITE_IN,
  input wire logic REQ_BANK_IN,
  input wire logic REQ_EXT_MASTER_IN,
  input wire logic [1:0] REQ_SIZE_IN,
  input wire logic [ADDR_W-1:0] REQ_ADDR_IN,
  input wire logic [1:0] BANK0_PORT_SIZE_IN,
  input wire logic [1:0] BANK1_PORT_SIZE_IN,
  input wire logic [3:0] BANK0_COL_BITS_IN,
  input wire logic [3:0] BANK1_COL_BITS_IN,
  input wire logic [1:0] PAGE_MODE_IN,
  input wire logic EDO_IN,
  input wire logic EXT_ADDR_MUX_EN_IN,
  input wire logic [TMR_W-1:0] DRAM_TIMING_REGISTER_IN,
  input wire logic [RATE_W-1:0] REFRESH_RATE_IN,
  output logic [1:0] RAS_N_OUT,
  output logic [3:0] CAS_N_OUT,
  output logic DRAM_WRITE_STROBE_N_OUT,
  output logic [ADDR_W-1:0] ADDR_OUT,
  output logic [1:0] TRANSFER_SIZE_OUT,
  output logic REQ_DONE_OUT,
  output logic DATA_STROBE_OUT,
  output logic BUSY_OUT,
  output logic REFRESH_ACTIVE_OUT
);

  dsl_regs_t r_ff;
  dsl_regs_t nxt_r;
  dsl_lane_if lane_if ();

  dsl_lane_dec u_lane_dec (
    .lane (lane_if.dec)
  );

  function automatic logic [4:0] size_bytes(input logic [1:0] sz);
    case (sz)
      SIZE_BYTE: size_bytes = 5'h01;
      SIZE_WORD: size_bytes = 5'h02;
      SIZE_LINE: size_bytes = 5'h10;
      default: size_bytes = 5'h04;
    endcase
  endfunction : size_bytes

  function automatic logic [4:0] port_bytes(input logic [1:0] ps);
    case (ps)
      PORT_8: port_bytes = 5'h01;
      PORT_16A, PORT_16B: port_bytes = 5'h02;
      default: port_bytes = 5'h04;
    endcase
  endfunction : port_bytes

  // Beats needed when the operand is wider than the port
  function automatic logic [4:0] beat_count(input logic [1:0] sz, input logic [1:0] ps);
    logic [4:0] ob;
    logic [4:0] pb;
    ob = size_bytes(sz);
    pb = port_bytes(ps);
    if (ob <= pb) begin
      beat_count = 5'h01;
    end else if (pb == 5'h01) begin
      beat_count = ob;
    end else if (pb == 5'h02) begin
      beat_count = ob >> 1;
    end else begin
      beat_count = ob >> 2;
    end
  endfunction : beat_count

  function automatic logic [ADDR_W-1:0] row_of(input logic [ADDR_W-1:0] a,
                                               input logic [3:0] cb);
    row_of = a >> cb;
  endfunction : row_of

  function automatic logic [2:0] tfield(input logic [TMR_W-1:0] t, input int lsb);
    tfield = {1'b0, t[lsb +: TMR_FIELD_W]};
  endfunction : tfield

  logic take_new;
  logic [1:0] bank_port;
  logic [3:0] bank_cols;
  logic [ADDR_W-1:0] col_mask;
  logic [RTMR_W-1:0] rtmr_load;
  logic mux_en;

  // A fresh request is decoded straight from the inputs in idle and open-page states
  assign take_new = (r_ff.st == ST_IDLE) || (r_ff.st == ST_PAGE);
  assign bank_port = (take_new ? REQ_BANK_IN : r_ff.bank) ? BANK1_PORT_SIZE_IN
                                                            : BANK0_PORT_SIZE_IN;
  assign bank_cols = (take_new ? REQ_BANK_IN : r_ff.bank) ? BANK1_COL_BITS_IN
                                                            : BANK0_COL_BITS_IN;
  assign col_mask = (ADDR_W'(1) << bank_cols) - ADDR_W'(1);
  // Count runs from load down to zero, so load one less than the period
  assign rtmr_load = RTMR_W'((32'(REFRESH_RATE_IN) + 32'd1) * REFRESH_UNIT_P - 32'd1);
  assign mux_en = !r_ff.ext || EXT_ADDR_MUX_EN_IN;

  assign lane_if.op_size = take_new ? REQ_SIZE_IN : r_ff.size;
  assign lane_if.port_size = bank_port;
  assign lane_if.addr_lo = take_new ? REQ_ADDR_IN[1:0] : r_ff.addr[1:0];

  always_comb begin
    nxt_r = r_ff;
    nxt_r.done = 1'b0;
    nxt_r.data_stb = r_ff.edo_stb;
    nxt_r.edo_stb = 1'b0;
    if (r_ff.cnt != 3'h0) begin
      nxt_r.cnt = r_ff.cnt - 3'h1;
    end
    // Refresh timer runs in every state; a set in the clearing cycle is kept
    if (r_ff.rtmr == '0) begin
      nxt_r.rtmr = rtmr_load;
      nxt_r.rfsh_pend = 1'b1;
    end else begin
      nxt_r.rtmr = r_ff.rtmr - RTMR_W'(1);
    end
    case (r_ff.st)
      ST_IDLE: begin
        nxt_r.we_n = 1'b1;
        if (r_ff.rfsh_pend) begin
          nxt_r.st = ST_RF_CAS;
          nxt_r.cas_n = CAS_ALL_ON;
          nxt_r.we_n = 1'b1;
          nxt_r.rfsh_act = 1'b1;
          nxt_r.busy = 1'b1;
          nxt_r.cnt = 3'h0;
          if (r_ff.rtmr != '0) begin
            nxt_r.rfsh_pend = 1'b0;
          end
        end else if (REQ_VALID_IN && !r_ff.done) begin
          nxt_r.st = ST_ROW;
          nxt_r.busy = 1'b1;
          nxt_r.addr = REQ_ADDR_IN;
          nxt_r.size = REQ_SIZE_IN;
          nxt_r.wr = REQ_WRITE_IN;
          nxt_r.bank = REQ_BANK_IN;
          nxt_r.ext = REQ_EXT_MASTER_IN;
          nxt_r.beats = beat_count(REQ_SIZE_IN, bank_port);
          nxt_r.tsize = REQ_SIZE_IN;
          nxt_r.open_row = row_of(REQ_ADDR_IN, bank_cols);
          nxt_r.addr_out = (!REQ_EXT_MASTER_IN || EXT_ADDR_MUX_EN_IN)
                           ? row_of(REQ_ADDR_IN, bank_cols) : REQ_ADDR_IN;
          nxt_r.ras_n = REQ_BANK_IN ? 2'h1 : 2'h2;
          nxt_r.cnt = tfield(DRAM_TIMING_REGISTER_IN, TMR_RCD_LSB);
        end else begin
          nxt_r.busy = 1'b0;
        end
      end
      ST_ROW: begin
        if (r_ff.cnt == 3'h0) begin
          nxt_r.st = ST_COL;
          nxt_r.addr_out = mux_en ? (r_ff.addr & col_mask) : r_ff.addr;
          nxt_r.cas_n = lane_if.cas_n;
          nxt_r.we_n = !r_ff.wr;
          nxt_r.cnt = tfield(DRAM_TIMING_REGISTER_IN, TMR_CASW_LSB);
        end
      end
      ST_COL: begin
        if (r_ff.cnt == 3'h0) begin
          nxt_r.cas_n = CAS_NONE_N;
          // EDO parts hold data after the column strobe rises, so strobe a cycle later
          nxt_r.data_stb = r_ff.edo_stb || !EDO_IN;
          nxt_r.edo_stb = EDO_IN;
          nxt_r.beats = r_ff.beats - 5'h01;
          nxt_r.addr = r_ff.addr + ADDR_W'(port_bytes(bank_port));
          if (r_ff.beats != 5'h01) begin
            if (PAGE_MODE_IN == MODE_BURST_PAGE) begin
              nxt_r.st = ST_CGAP;
            end else begin
              nxt_r.st = ST_PRE;
              nxt_r.ras_n = RAS_OFF_N;
              nxt_r.we_n = 1'b1;
              nxt_r.cnt = tfield(DRAM_TIMING_REGISTER_IN, TMR_RP_LSB);
            end
          end else begin
            nxt_r.done = 1'b1;
            nxt_r.we_n = 1'b1;
            if (PAGE_MODE_IN == MODE_NORMAL) begin
              nxt_r.st = ST_PRE;
              nxt_r.ras_n = RAS_OFF_N;
              nxt_r.cnt = tfield(DRAM_TIMING_REGISTER_IN, TMR_RP_LSB);
            end else begin
              nxt_r.st = ST_PAGE;
            end
          end
        end
      end
      ST_CGAP: begin
        // Burst beat: row stays open, only the column moves
        nxt_r.st = ST_COL;
        nxt_r.addr_out = mux_en ? (r_ff.addr & col_mask) : r_ff.addr;
        nxt_r.cas_n = lane_if.cas_n;
        nxt_r.cnt = tfield(DRAM_TIMING_REGISTER_IN, TMR_CASW_LSB);
      end
      ST_PAGE: begin
        // Row held open; a hit on the same bank and row skips the row phase
        if (r_ff.rfsh_pend) begin
          nxt_r.st = ST_PRE;
          nxt_r.ras_n = RAS_OFF_N;
          nxt_r.cnt = tfield(DRAM_TIMING_REGISTER_IN, TMR_RP_LSB);
        end else if (REQ_VALID_IN && !r_ff.done) begin
          if (REQ_BANK_IN == r_ff.bank && row_of(REQ_ADDR_IN, bank_cols) == r_ff.open_row) begin
            nxt_r.st = ST_COL;
            nxt_r.addr = REQ_ADDR_IN;
            nxt_r.size = REQ_SIZE_IN;
            nxt_r.wr = REQ_WRITE_IN;
            nxt_r.ext = REQ_EXT_MASTER_IN;
            nxt_r.beats = beat_count(REQ_SIZE_IN, bank_port);
            nxt_r.tsize = REQ_SIZE_IN;
            nxt_r.addr_out = (!REQ_EXT_MASTER_IN || EXT_ADDR_MUX_EN_IN)
                             ? (REQ_ADDR_IN & col_mask) : REQ_ADDR_IN;
            nxt_r.cas_n = lane_if.cas_n;
            nxt_r.we_n = !REQ_WRITE_IN;
            nxt_r.cnt = tfield(DRAM_TIMING_REGISTER_IN, TMR_CASW_LSB);
          end else begin
            // Page miss: close the row, the held request is served afterwards
            nxt_r.st = ST_PRE;
            nxt_r.ras_n = RAS_OFF_N;
            nxt_r.cnt = tfield(DRAM_TIMING_REGISTER_IN, TMR_RP_LSB);
          end
        end
      end
      ST_PRE: begin
        nxt_r.cas_n = CAS_NONE_N;
        nxt_r.ras_n = RAS_OFF_N;
        nxt_r.we_n = 1'b1;
        if (r_ff.cnt == 3'h0) begin
          nxt_r.rfsh_act = 1'b0;
          if (r_ff.beats != 5'h00 && !r_ff.rfsh_act) begin
            // Next beat of a split transfer in normal or fast page mode
            nxt_r.st = ST_ROW;
            nxt_r.addr_out = mux_en ? row_of(r_ff.addr, bank_cols) : r_ff.addr;
            nxt_r.ras_n = r_ff.bank ? 2'h1 : 2'h2;
            nxt_r.cnt = tfield(DRAM_TIMING_REGISTER_IN, TMR_RCD_LSB);
          end else begin
            nxt_r.st = ST_IDLE;
          end
        end
      end
      ST_RF_CAS: begin
        nxt_r.st = ST_RF_RAS;
        nxt_r.ras_n = 2'h0;
        nxt_r.we_n = 1'b1;
        nxt_r.cnt = tfield(DRAM_TIMING_REGISTER_IN, TMR_RFSH_LSB);
      end
      ST_RF_RAS: begin
        nxt_r.we_n = 1'b1;
        if (r_ff.cnt == 3'h0) begin
          nxt_r.st = ST_PRE;
          nxt_r.ras_n = RAS_OFF_N;
          nxt_r.cas_n = CAS_ALL_N;
          nxt_r.beats = 5'h00;
          nxt_r.cnt = tfield(DRAM_TIMING_REGISTER_IN, TMR_RP_LSB);
        end
      end
      default: begin
        nxt_r.st = ST_IDLE;
        nxt_r.ras_n = RAS_OFF_N;
        nxt_r.cas_n = CAS_NONE_N;
        nxt_r.we_n = 1'b1;
      end
    endcase
  end

  // Timer starts at the shortest period, as for rate zero, so refresh begins without software
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      r_ff <= '{st: ST_IDLE, cnt: 3'h0, beats: 5'h00, addr: '0, size: SIZE_LONG,
                wr: 1'b0, bank: 1'b0, ext: 1'b0, open_row: '0,
                rtmr: RTMR_W'(REFRESH_UNIT_P - 1), rfsh_pend: 1'b0, ras_n: RAS_OFF_N,
                cas_n: CAS_NONE_N, we_n: 1'b1, addr_out: '0, tsize: SIZE_LONG,
                done: 1'b0, data_stb: 1'b0, edo_stb: 1'b0, busy: 1'b0,
                rfsh_act: 1'b0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign RAS_N_OUT = r_ff.ras_n;
  assign CAS_N_OUT = r_ff.cas_n;
  assign DRAM_WRITE_STROBE_N_OUT = r_ff.we_n;
  assign ADDR_OUT = r_ff.addr_out;
  assign TRANSFER_SIZE_OUT = r_ff.tsize;
  assign REQ_DONE_OUT = r_ff.done;
  assign DATA_STROBE_OUT = r_ff.data_stb;
  assign BUSY_OUT = r_ff.busy;
  assign REFRESH_ACTIVE_OUT = r_ff.rfsh_act;

endmodule : dsl_top

// ### testbench/dsl_dram_model.sv
`timescale 1ns/100ps
module dsl_dram_model
  import dsl_pkg::*;
(
  input wire logic clk_in,
  input wire logic clr_in,
  input wire logic [1:0] ras_n_in,
  input wire logic [3:0] cas_n_in,
  input wire logic we_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  output logic got_out,
  output logic [ADDR_W-1:0] addr_seen_out,
  output logic [3:0] cas_seen_out,
  output logic [1:0] ras_seen_out,
  output logic we_seen_out,
  output int rfsh_cnt_out
);
  logic [3:0] cas_prev;
  initial begin
    got_out = 1'b0;
    rfsh_cnt_out = 0;
    cas_prev = 4'hF;
  end
  always @(posedge clk_in) begin
    if (clr_in) begin
      got_out <= 1'b0;
    end else if (!got_out && cas_prev == 4'hF && cas_n_in != 4'hF && ras_n_in != 2'h3) begin
      // Write strobe only taken at a column fall with a row open
      got_out <= 1'b1;
      cas_seen_out <= cas_n_in;
      addr_seen_out <= addr_in;
      ras_seen_out <= ras_n_in;
      we_seen_out <= we_n_in;
    end
    // Column before row with no row open is a refresh
    if (cas_prev == 4'hF && cas_n_in == 4'h0 && ras_n_in == 2'h3) begin
      rfsh_cnt_out <= rfsh_cnt_out + 1;
    end
    cas_prev <= cas_n_in;
  end
endmodule : dsl_dram_model

// ### testbench/dsl_top_props.sv
`timescale 1ns/100ps
module dsl_top_props
  import dsl_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic REQ_VALID_IN,
  input wire logic REQ_WRITE_IN,
  input wire logic [1:0] REQ_SIZE_IN,
  input wire logic [1:0] BANK0_PORT_SIZE_IN,
  input wire logic [1:0] RAS_N_OUT,
  input wire logic [3:0] CAS_N_OUT,
  input wire logic DRAM_WRITE_STROBE_N_OUT,
  input wire logic [1:0] TRANSFER_SIZE_OUT,
  input wire logic REQ_DONE_OUT,
  input wire logic BUSY_OUT,
  input wire logic REFRESH_ACTIVE_OUT
);
  default clocking cb_chk @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  logic xfer_cas;
  // Column phase of a held transfer, refresh excluded
  assign xfer_cas = (CAS_N_OUT != CAS_NONE_N) && !REFRESH_ACTIVE_OUT && REQ_VALID_IN;

  a_we_refresh_high: assert property (REFRESH_ACTIVE_OUT |-> DRAM_WRITE_STROBE_N_OUT)
    else $error("write strobe low during refresh");
  a_cbr_cas_first: assert property ((REFRESH_ACTIVE_OUT && RAS_N_OUT == 2'h0
    && $past(RAS_N_OUT) == RAS_OFF_N) |-> $past(CAS_N_OUT) == CAS_ALL_ON)
    else $error("refresh row strobes without column strobes first");
  a_ras_one_bank: assert property (!REFRESH_ACTIVE_OUT |-> RAS_N_OUT != 2'h0)
    else $error("both row strobes low outside refresh");
  a_lane_narrow: assert property ((!REFRESH_ACTIVE_OUT && !RAS_N_OUT[0]
    && BANK0_PORT_SIZE_IN == PORT_8) |-> CAS_N_OUT[3:1] == 3'h7)
    else $error("unused lane strobed on narrow bank");
  a_size_matches: assert property (xfer_cas |-> TRANSFER_SIZE_OUT == REQ_SIZE_IN)
    else $error("transfer size differs from operand size");
  a_we_direction: assert property (xfer_cas
    |-> DRAM_WRITE_STROBE_N_OUT == !REQ_WRITE_IN)
    else $error("write strobe disagrees with direction");
  a_done_single: assert property (REQ_DONE_OUT |=> !REQ_DONE_OUT)
    else $error("done held longer than one cycle");
  a_idle_cas_high: assert property ((!BUSY_OUT && !REFRESH_ACTIVE_OUT)
    |-> CAS_N_OUT == CAS_NONE_N)
    else $error("column strobe asserted while idle");
  a_refresh_bounded: assert property ($rose(REFRESH_ACTIVE_OUT)
    |-> ##[1:40] !REFRESH_ACTIVE_OUT)
    else $error("refresh never released");
endmodule : dsl_top_props

bind dsl_top dsl_top_props u_props (
  .CORE_CLK_IN(CORE_CLK_IN),
  .RST_N_IN(RST_N_IN),
  .REQ_VALID_IN(REQ_VALID_IN),
  .REQ_WRITE_IN(REQ_WRITE_IN),
  .REQ_SIZE_IN(REQ_SIZE_IN),
  .BANK0_PORT_SIZE_IN(BANK0_PORT_SIZE_IN),
  .RAS_N_OUT(RAS_N_OUT),
  .CAS_N_OUT(CAS_N_OUT),
  .DRAM_WRITE_STROBE_N_OUT(DRAM_WRITE_STROBE_N_OUT),
  .TRANSFER_SIZE_OUT(TRANSFER_SIZE_OUT),
  .REQ_DONE_OUT(REQ_DONE_OUT),
  .BUSY_OUT(BUSY_OUT),
  .REFRESH_ACTIVE_OUT(REFRESH_ACTIVE_OUT)
);

// ### testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top
  import dsl_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic valid, wr, bank, ext, mux_en, edo, clr, got, m_we;
  logic [1:0] size, p0, p1, mode, m_ras, ras_n, tsize;
  logic [3:0] cb0, cb1, cas_n, m_cas;
  logic [ADDR_W-1:0] addr, addr_o, m_addr;
  logic [TMR_W-1:0] tmr;
  logic [RATE_W-1:0] rate;
  logic we_n, done, dstb, busy, ract;
  logic [31:0] rv;
  int rcnt, r0;
  int num_errors = 0;
  int check_count = 0;
  integer seed = 32'h2573;

  always #5 clk = ~clk;

  dsl_top #(.REFRESH_UNIT_P(1)) u_dut (
    .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .REQ_VALID_IN(valid), .REQ_WRITE_IN(wr),
    .REQ_BANK_IN(bank), .REQ_EXT_MASTER_IN(ext), .REQ_SIZE_IN(size), .REQ_ADDR_IN(addr),
    .BANK0_PORT_SIZE_IN(p0), .BANK1_PORT_SIZE_IN(p1), .BANK0_COL_BITS_IN(cb0),
    .BANK1_COL_BITS_IN(cb1), .PAGE_MODE_IN(mode), .EDO_IN(edo), .EXT_ADDR_MUX_EN_IN(mux_en),
    .DRAM_TIMING_REGISTER_IN(tmr), .REFRESH_RATE_IN(rate), .RAS_N_OUT(ras_n),
    .CAS_N_OUT(cas_n), .DRAM_WRITE_STROBE_N_OUT(we_n), .ADDR_OUT(addr_o),
    .TRANSFER_SIZE_OUT(tsize), .REQ_DONE_OUT(done), .DATA_STROBE_OUT(dstb),
    .BUSY_OUT(busy), .REFRESH_ACTIVE_OUT(ract)
  );

  dsl_dram_model u_dram (
    .clk_in(clk), .clr_in(clr), .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n),
    .addr_in(addr_o), .got_out(got), .addr_seen_out(m_addr),
    .cas_seen_out(m_cas), .ras_seen_out(m_ras), .we_seen_out(m_we),
    .rfsh_cnt_out(rcnt)
  );

  function automatic logic [3:0] exp_cas(logic [1:0] s, logic [1:0] p, logic [1:0] a);
    if (p == PORT_8) return 4'hE;
    if (p[1]) return (s == SIZE_BYTE) ? (a[0] ? 4'hD : 4'hE) : 4'hC;
    case (s)
      SIZE_BYTE: return ~(4'h1 << a);
      SIZE_WORD: return a[1] ? 4'h3 : 4'hC;
      default: return 4'h0;
    endcase
  endfunction : exp_cas

  // Beats per transfer: operand bytes over port bytes, at least one
  function automatic int exp_beats(logic [1:0] s, logic [1:0] p);
    int ob;
    int pb;
    ob = (s == SIZE_BYTE) ? 1 : (s == SIZE_WORD) ? 2 : (s == SIZE_LINE) ? 16 : 4;
    pb = (p == PORT_8) ? 1 : (p[1] ? 2 : 4);
    return (ob > pb) ? ob / pb : 1;
  endfunction : exp_beats

  // Misaligned operands are outside what the lane decode accepts
  function automatic logic [1:0] align(logic [1:0] s, logic [1:0] a);
    return (s == SIZE_BYTE) ? a : (s == SIZE_WORD) ? {a[1], 1'b0} : 2'h0;
  endfunction : align

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : check

  task automatic stop_test;
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic xfer(input logic [1:0] s, input logic [1:0] p, input logic [1:0] a);
    int n;
    int ns;
    logic seen_done;
    logic [3:0] cb;
    logic [ADDR_W-1:0] col;
    @(posedge clk);
    #1;
    rv = $random(seed);
    wr = rv[0];
    bank = rv[1];
    mode = rv[3:2];
    edo = rv[4];
    ext = rv[5];
    mux_en = rv[6];
    tmr = rv[15:8];
    cb0 = {1'b1, rv[18:16]};
    cb1 = {1'b1, rv[21:19]};
    p0 = bank ? rv[23:22] : p;
    p1 = bank ? p : rv[23:22];
    size = s;
    addr = {rv[31:24], rv[21:4], align(s, a)};
    clr = 1'b1;
    @(posedge clk);
    #1;
    valid = 1'b1;
    clr = 1'b0;
    seen_done = 1'b0;
    ns = 0;
    for (n = 0; n < 600 && !seen_done; n++) begin
      @(posedge clk);
      #1;
      if (dstb === 1'b1) ns++;
      if (done === 1'b1) begin
        seen_done = 1'b1;
        check(tsize, s, "transfer size");
      end
    end
    if (!seen_done) begin
      check(0, 1, "no done");
      stop_test();
    end
    valid = 1'b0;
    // EDO parts give the last data strobe one cycle after done
    @(posedge clk);
    #1;
    if (dstb === 1'b1) ns++;
    cb = bank ? cb1 : cb0;
    col = (!ext || mux_en) ? (addr & ((ADDR_W'(1) << cb) - ADDR_W'(1))) : addr;
    check(got, 1, "no column strobe seen");
    check(m_cas, exp_cas(s, p, align(s, a)), "lane strobes");
    check(m_ras, bank ? 2'h1 : 2'h2, "row strobe bank");
    check(m_we, !wr, "write strobe");
    check(m_addr, col, "column address");
    check(ns, exp_beats(s, p), "data strobes per transfer");
  endtask : xfer

  initial begin
    valid = 1'b0;
    wr = 1'b0;
    bank = 1'b0;
    ext = 1'b0;
    mux_en = 1'b1;
    edo = 1'b0;
    clr = 1'b0;
    size = 2'h0;
    p0 = 2'h0;
    p1 = 2'h0;
    mode = 2'h0;
    cb0 = 4'h8;
    cb1 = 4'h9;
    addr = '0;
    tmr = '0;
    rate = 12'h00F;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    // Idle pacing: 16 cycle period plus refresh length slack
    repeat (20) @(posedge clk);
    r0 = rcnt;
    repeat (160) @(posedge clk);
    check((rcnt - r0 >= 7) && (rcnt - r0 <= 11), 1, "refresh pacing");
    #1;
    rate = 12'h03F;
    r0 = rcnt;
    for (int s = 0; s < 4; s++)
      for (int p = 0; p < 4; p++)
        for (int a = 0; a < 4; a++)
          xfer(2'(s), 2'(p), 2'(a));
    for (int i = 0; i < 40; i++) begin
      rv = $random(seed);
      xfer(rv[1:0], rv[3:2], rv[5:4]);
    end
    check(rcnt > r0, 1, "refresh during traffic");
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    #1;
    check(cas_n, 4'hF, "column strobes in reset");
    check(ras_n, 2'h3, "row strobes in reset");
    stop_test();
  end
endmodule : tb_top
